// *** core/gms_seq.sv ***
// Generator-set operating-mode sequencer with AXI4-Lite registers.
// Assumes pins are asynchronous and sequencing inputs are handshake levels.
`timescale 1ns/10ps
module gms_seq #(
  parameter int N_REQ = gms_pkg::REQ_W,
  parameter int N_ALM = gms_pkg::ALM_W,
  parameter int TICK_CYC = gms_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [gms_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [gms_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic btn_stop,
  input wire logic btn_manual,
  input wire logic btn_auto,
  input wire logic btn_start,
  input wire logic transfer_on_load_button,
  input wire logic btn_open,
  input wire logic din_on_load,
  input wire logic din_off_load,
  input wire logic gen_available,
  input wire logic in_sync,
  input wire logic bus_live,
  input wire logic ramp_done,
  input wire logic [N_REQ-1:0] inter_set_comms_link,
  input wire logic [N_ALM-1:0] alarm_cond,
  output logic engine_run,
  output logic sync_req,
  output logic ramp_off_req,
  output logic gen_close,
  output logic [1:0] op_mode,
  output logic irq
);
  import gms_pkg::*;

  localparam int IN_W = IN_BASE_W + N_REQ + N_ALM;

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = (o & ~strb_mask(s)) | (d & strb_mask(s));
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisation and edge detection
  // ----------------------------------------------------------------
  logic [IN_W-1:0] pins_s;
  logic [IN_BASE_W-1:0] prev_reg;
  logic [IN_BASE_W-1:0] rise;
  logic [N_REQ-1:0] req_s;
  logic [N_ALM-1:0] cond_s;

  gms_in_sync #(.W(IN_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .din({alarm_cond, inter_set_comms_link, ramp_done, bus_live, in_sync,
          gen_available, din_off_load, din_on_load, btn_open,
          transfer_on_load_button, btn_start, btn_auto, btn_manual, btn_stop}),
    .dout(pins_s)
  );

  assign rise = pins_s[IN_BASE_W-1:0] & ~prev_reg;
  assign req_s = pins_s[IN_BASE_W +: N_REQ];
  assign cond_s = pins_s[IN_BASE_W+N_REQ +: N_ALM];

  // ----------------------------------------------------------------
  // Timer tick divider
  // ----------------------------------------------------------------
  logic [31:0] div_reg;
  logic [31:0] div_next;
  logic tick_reg;
  logic tick_next;

  always_comb begin
    tick_next = (div_reg == 32'(TICK_CYC - 1));
    div_next = tick_next ? 32'h0 : div_reg + 32'h1;
  end

  // ----------------------------------------------------------------
  // Mode and generator sequencing
  // ----------------------------------------------------------------
  gms_mode_e mode_reg, mode_next;
  gms_gen_e st_reg, st_next;
  logic [15:0] tmr_reg, tmr_next, ret_reg, cool_reg;
  logic [N_ALM-1:0] alm_reg, alm_next;
  logic run_next, close_next, stop_ev, man_ev, auto_ev, any_req;
  logic close_req, open_req, start_ev;

  always_comb begin
    stop_ev = rise[IN_STOP];
    man_ev = rise[IN_MAN];
    auto_ev = rise[IN_AUTO];
    start_ev = rise[IN_START];
    any_req = |req_s;
    mode_next = mode_reg;
    st_next = st_reg;
    tmr_next = tmr_reg;
    // Stop outranks manual outranks auto on a simultaneous press
    if (stop_ev) begin
      mode_next = MODE_STOP;
    end else if (man_ev) begin
      mode_next = MODE_MAN;
    end else if (auto_ev) begin
      mode_next = MODE_AUTO;
    end
    // Buttons and digital inputs share one request path
    close_req = (mode_next == MODE_MAN) ? (rise[IN_XFER] | rise[IN_ONLD]) : any_req;
    open_req = rise[IN_OPEN] | rise[IN_OFFLD];
    alm_next = stop_ev ? (alm_reg & cond_s) : (alm_reg | cond_s);
    if (mode_next == MODE_STOP) begin
      st_next = G_REST;
      tmr_next = 16'h0;
    end else begin
      unique case (st_reg)
        G_REST: begin
          if ((mode_next == MODE_MAN && start_ev) || (mode_next == MODE_AUTO && any_req)) begin
            st_next = G_RUN_OFF;
          end
        end
        G_RUN_OFF: begin
          if (mode_next == MODE_AUTO && !any_req) begin
            st_next = G_COOL;
            tmr_next = cool_reg;
          end else if (close_req && pins_s[IN_AVAIL]) begin
            st_next = pins_s[IN_BUSLIVE] ? G_SYNC : G_ON_LOAD;
          end
        end
        G_SYNC: begin
          if (pins_s[IN_INSYNC]) begin
            st_next = G_ON_LOAD;
          end else if ((mode_next == MODE_MAN && open_req) ||
                       (mode_next == MODE_AUTO && !any_req)) begin
            st_next = G_RUN_OFF;
          end
        end
        G_ON_LOAD: begin
          if (mode_next == MODE_MAN && open_req) begin
            st_next = G_RAMP;
          end else if (mode_next == MODE_AUTO && !any_req) begin
            st_next = G_RET_DELAY;
            tmr_next = ret_reg;
          end
        end
        G_RET_DELAY: begin
          if (mode_next == MODE_MAN || any_req) begin
            st_next = G_ON_LOAD;
          end else if (tick_reg && tmr_reg == 16'h0) begin
            // Expiry waits for a tick after zero so the full set delay always elapses
            st_next = G_RAMP;
          end else if (tick_reg) begin
            tmr_next = tmr_reg - 16'h1;
          end
        end
        G_RAMP: begin
          if (pins_s[IN_RAMPDN]) begin
            st_next = (mode_next == MODE_AUTO) ? G_COOL : G_RUN_OFF;
            tmr_next = cool_reg;
          end
        end
        G_COOL: begin
          if (mode_next == MODE_MAN || any_req) begin
            st_next = G_RUN_OFF;
          end else if (tick_reg && tmr_reg == 16'h0) begin
            st_next = G_REST;
          end else if (tick_reg) begin
            tmr_next = tmr_reg - 16'h1;
          end
        end
      endcase
    end
    // Switch stays closed through the ramp; opens once ramp is done, or at once on stop
    run_next = (st_next != G_REST);
    close_next = (st_next == G_ON_LOAD) || (st_next == G_RET_DELAY) ||
                 (st_next == G_RAMP);
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave and registers
  // ----------------------------------------------------------------
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [AXI_AW-1:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_next, rvalid_next, do_write, ar_take;
  logic [1:0] bresp_next, rresp_next;
  logic [EV_W-1:0] ist_reg, ist_next, imask_reg, imask_next, ev;
  logic [15:0] ret_next, cool_next;
  logic [31:0] status_w;

  always_comb begin
    do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
    aw_held_next = do_write ? 1'b0 : (aw_held_reg | (s_axi_awvalid & s_axi_awready));
    w_held_next = do_write ? 1'b0 : (w_held_reg | (s_axi_wvalid & s_axi_wready));
    awaddr_next = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_reg;
    wdata_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_reg;
    wstrb_next = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_reg;
    bvalid_next = do_write | (s_axi_bvalid & ~s_axi_bready);
    bresp_next = s_axi_bresp;
    imask_next = imask_reg;
    ret_next = ret_reg;
    cool_next = cool_reg;
    ev = '0;
    ev[EV_MODE] = (mode_next != mode_reg);
    ev[EV_CLOSE] = close_next & ~gen_close;
    ev[EV_OPEN] = ~close_next & gen_close;
    ev[EV_ENG_STOP] = engine_run & ~run_next;
    ev[EV_ALARM] = |(cond_s & ~alm_reg);
    // New events win over a write-one-to-clear in the same cycle
    ist_next = ist_reg | ev;
    if (do_write) begin
      bresp_next = RESP_OKAY;
      unique case (awaddr_reg)
        ADDR_STATUS, ADDR_ALARMS: ;
        ADDR_INT_STAT: ist_next = (ist_reg & ~EV_W'(wdata_reg & strb_mask(wstrb_reg))) | ev;
        ADDR_INT_MASK: imask_next = EV_W'(merge(32'(imask_reg), wdata_reg, wstrb_reg));
        ADDR_RET_DELAY: ret_next = 16'(merge(32'(ret_reg), wdata_reg, wstrb_reg));
        ADDR_COOL_TIME: cool_next = 16'(merge(32'(cool_reg), wdata_reg, wstrb_reg));
        default: bresp_next = RESP_SLVERR;
      endcase
    end
    status_w = '0;
    status_w[ST_MODE_LSB +: 2] = mode_reg;
    status_w[ST_STATE_LSB +: 3] = st_reg;
    status_w[ST_RUN_BIT] = engine_run;
    status_w[ST_CLOSE_BIT] = gen_close;
    ar_take = s_axi_arvalid & s_axi_arready;
    rvalid_next = ar_take | (s_axi_rvalid & ~s_axi_rready);
    rdata_next = s_axi_rdata;
    rresp_next = s_axi_rresp;
    if (ar_take) begin
      rresp_next = RESP_OKAY;
      unique case (s_axi_araddr)
        ADDR_STATUS: rdata_next = status_w;
        ADDR_INT_STAT: rdata_next = 32'(ist_reg);
        ADDR_INT_MASK: rdata_next = 32'(imask_reg);
        ADDR_RET_DELAY: rdata_next = 32'(ret_reg);
        ADDR_COOL_TIME: rdata_next = 32'(cool_reg);
        ADDR_ALARMS: rdata_next = 32'(alm_reg);
        default: begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_reg <= '0;
      div_reg <= 32'h0;
      tick_reg <= 1'b0;
      mode_reg <= MODE_STOP;
      st_reg <= G_REST;
      tmr_reg <= 16'h0;
      alm_reg <= '0;
      engine_run <= 1'b0;
      gen_close <= 1'b0;
      sync_req <= 1'b0;
      ramp_off_req <= 1'b0;
      op_mode <= 2'h0;
      irq <= 1'b0;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
      ist_reg <= '0;
      imask_reg <= '0;
      ret_reg <= RET_DELAY_RST;
      cool_reg <= COOL_TIME_RST;
    end else begin
      prev_reg <= pins_s[IN_BASE_W-1:0];
      div_reg <= div_next;
      tick_reg <= tick_next;
      mode_reg <= mode_next;
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      alm_reg <= alm_next;
      engine_run <= run_next;
      gen_close <= close_next;
      sync_req <= (st_next == G_SYNC);
      ramp_off_req <= (st_next == G_RAMP);
      op_mode <= mode_next;
      irq <= |(ist_next & imask_next);
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      s_axi_awready <= ~aw_held_next & ~bvalid_next;
      s_axi_wready <= ~w_held_next & ~bvalid_next;
      s_axi_bvalid <= bvalid_next;
      s_axi_bresp <= bresp_next;
      s_axi_arready <= ~rvalid_next;
      s_axi_rvalid <= rvalid_next;
      s_axi_rdata <= rdata_next;
      s_axi_rresp <= rresp_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      ret_reg <= ret_next;
      cool_reg <= cool_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_alarm_clear;
    stop_ev |=> alm_reg == ($past(alm_reg) & $past(cond_s));
  endproperty
  a_alarm_clear: assert property (p_alarm_clear) else $error("alarm clear wrong");

  property p_stop_open;
    stop_ev |=> !gen_close && op_mode == MODE_STOP;
  endproperty
  a_stop_open: assert property (p_stop_open) else $error("stop left switch closed");

  property p_stop_rest;
    mode_reg == MODE_STOP |-> !engine_run && st_reg == G_REST;
  endproperty
  a_stop_rest: assert property (p_stop_rest) else $error("engine run in stop");

  property p_man_start;
    mode_reg == MODE_MAN && st_reg == G_REST && start_ev && !stop_ev && !auto_ev
      |=> engine_run && !gen_close;
  endproperty
  a_man_start: assert property (p_man_start) else $error("manual start failed");

  property p_close_cause;
    $rose(gen_close) |-> $past(pins_s[IN_INSYNC]) || !$past(pins_s[IN_BUSLIVE]);
  endproperty
  a_close_cause: assert property (p_close_cause) else $error("closed out of sync");

  property p_open_after_ramp;
    $fell(gen_close) && op_mode != MODE_STOP |-> $past(st_reg) == G_RAMP;
  endproperty
  a_open_after_ramp: assert property (p_open_after_ramp) else $error("open w/o ramp");

  property p_man_hold;
    mode_reg == MODE_MAN && st_reg == G_ON_LOAD && !open_req && !stop_ev && !auto_ev
      |=> gen_close;
  endproperty
  a_man_hold: assert property (p_man_hold) else $error("manual load dropped");

  property p_auto_start;
    mode_reg == MODE_AUTO && st_reg == G_REST && any_req && !stop_ev && !man_ev
      |=> engine_run && st_reg == G_RUN_OFF;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto start failed");

  property p_cool_end;
    st_reg == G_COOL && tick_reg && tmr_reg == 16'h0 && !any_req && mode_next == MODE_AUTO
      |=> !engine_run && op_mode == MODE_AUTO && st_reg == G_REST;
  endproperty
  a_cool_end: assert property (p_cool_end) else $error("cooling end wrong");

  property p_dead_bus;
    st_reg == G_RUN_OFF && close_req && pins_s[IN_AVAIL] && !pins_s[IN_BUSLIVE] &&
      mode_next != MODE_STOP && !(mode_next == MODE_AUTO && !any_req) |=> gen_close;
  endproperty
  a_dead_bus: assert property (p_dead_bus) else $error("dead bus close late");

  property p_mode_pick;
    man_ev && !stop_ev |=> op_mode == MODE_MAN;
  endproperty
  a_mode_pick: assert property (p_mode_pick) else $error("mode press ignored");

  c_auto_cycle: cover property (st_reg == G_RET_DELAY ##[1:1000] st_reg == G_COOL);
  c_sync_close: cover property (st_reg == G_SYNC ##1 gen_close);
  c_irq: cover property ($rose(irq));

endmodule

// *** core/gms_pkg.sv ***
// Shared constants and types for the generator-set mode sequencer.
// Assumes a single 100 MHz clock and an AXI4-Lite register bus.
package gms_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1000000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Register map (byte addresses) and reset values
  // ----------------------------------------------------------------
  localparam int AXI_AW = 6;
  localparam logic [AXI_AW-1:0] ADDR_STATUS = 6'h00;
  localparam logic [AXI_AW-1:0] ADDR_INT_STAT = 6'h04;
  localparam logic [AXI_AW-1:0] ADDR_INT_MASK = 6'h08;
  localparam logic [AXI_AW-1:0] ADDR_RET_DELAY = 6'h0c;
  localparam logic [AXI_AW-1:0] ADDR_COOL_TIME = 6'h10;
  localparam logic [AXI_AW-1:0] ADDR_ALARMS = 6'h14;
  localparam logic [15:0] RET_DELAY_RST = 16'h1388;
  localparam logic [15:0] COOL_TIME_RST = 16'h2710;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status word fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_STATE_LSB = 2;
  localparam int ST_RUN_BIT = 5;
  localparam int ST_CLOSE_BIT = 6;

  // Interrupt event bits
  localparam int EV_MODE = 0;
  localparam int EV_CLOSE = 1;
  localparam int EV_OPEN = 2;
  localparam int EV_ENG_STOP = 3;
  localparam int EV_ALARM = 4;
  localparam int EV_W = 5;

  // ----------------------------------------------------------------
  // Pin vector layout
  // ----------------------------------------------------------------
  localparam int REQ_W = 4;
  localparam int ALM_W = 8;
  localparam int IN_STOP = 0;
  localparam int IN_MAN = 1;
  localparam int IN_AUTO = 2;
  localparam int IN_START = 3;
  localparam int IN_XFER = 4;
  localparam int IN_OPEN = 5;
  localparam int IN_ONLD = 6;
  localparam int IN_OFFLD = 7;
  localparam int IN_AVAIL = 8;
  localparam int IN_INSYNC = 9;
  localparam int IN_BUSLIVE = 10;
  localparam int IN_RAMPDN = 11;
  localparam int IN_BASE_W = 12;

  typedef enum logic [1:0] {MODE_STOP, MODE_MAN, MODE_AUTO} gms_mode_e;
  typedef enum logic [2:0] {
    G_REST, G_RUN_OFF, G_SYNC, G_ON_LOAD, G_RET_DELAY, G_RAMP, G_COOL
  } gms_gen_e;

endpackage

// *** core/gms_in_sync.sv ***
// Three-stage input synchroniser for asynchronous pins.
// Assumes the inputs are slow levels; output moves once stages 2 and 3 agree.
`timescale 1ns/10ps
module gms_in_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] ff1_reg;
  logic [W-1:0] ff2_reg;
  logic [W-1:0] ff3_reg;
  logic [W-1:0] out_reg;
  logic [W-1:0] out_next;

  // Stage 1 feeds stage 2 only; the agree test sits on stages 2 and 3
  always_comb begin
    out_next = out_reg;
    for (int i = 0; i < W; i++) begin
      if (ff2_reg[i] == ff3_reg[i]) begin
        out_next[i] = ff3_reg[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_reg <= '0;
      ff2_reg <= '0;
      ff3_reg <= '0;
      out_reg <= '0;
    end else begin
      ff1_reg <= din;
      ff2_reg <= ff1_reg;
      ff3_reg <= ff2_reg;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;

endmodule

// *** dv/gms_partner.sv ***
// Engine, load ramp and synchroniser model facing the mode sequencer.
// Assumes one clock; each answer follows its request after dly cycles.
`timescale 1ns/10ps
module gms_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic engine_run,
  input wire logic sync_req,
  input wire logic ramp_off_req,
  input wire logic [7:0] dly,
  output logic gen_available,
  output logic in_sync,
  output logic ramp_done
);
  // ----------------------------------------------------------------
  // Answers drop as soon as their request drops, as a real set would
  // ----------------------------------------------------------------
  logic [7:0] c_av_reg, c_sy_reg, c_rp_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      c_av_reg <= 8'h00;
      c_sy_reg <= 8'h00;
      c_rp_reg <= 8'h00;
    end else begin
      c_av_reg <= !engine_run ? 8'h00 : (c_av_reg == 8'hff ? c_av_reg : c_av_reg + 8'h01);
      c_sy_reg <= !sync_req ? 8'h00 : (c_sy_reg == 8'hff ? c_sy_reg : c_sy_reg + 8'h01);
      c_rp_reg <= !ramp_off_req ? 8'h00 : (c_rp_reg == 8'hff ? c_rp_reg : c_rp_reg + 8'h01);
    end
  end
  assign gen_available = engine_run && c_av_reg >= dly;
  assign in_sync = sync_req && c_sy_reg >= dly;
  assign ramp_done = ramp_off_req && c_rp_reg >= dly;
endmodule

// *** dv/gms_seq_bench.sv ***
// Self-checking bench for the mode sequencer: buttons, link and AXI4-Lite.
// Assumes the partner model closes the loop on engine, sync and ramp.
`timescale 1ns/10ps
module gms_seq_bench;
  import gms_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic aclk = 0, aresetn = 0;
  logic [5:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, op_mode;
  logic [31:0] rdata;
  logic [7:0] btn = 0, alm = 0, dly = 8'h01;
  logic [3:0] link = 0;
  logic bus_live = 0;
  logic engine_run, sync_req, ramp_off_req, gen_close, irq, gen_available, in_sync, ramp_done;
  logic [4:0] outs;
  int n_mismatch = 0, n_compared = 0, c;
  logic [31:0] d;
  logic [1:0] r;
  assign outs = {irq, gen_close, ramp_off_req, sync_req, engine_run};
  always #5 aclk = ~aclk;
  gms_seq #(.TICK_CYC(10)) i_gms_seq (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .btn_stop(btn[IN_STOP]), .btn_manual(btn[IN_MAN]), .btn_auto(btn[IN_AUTO]),
    .btn_start(btn[IN_START]), .transfer_on_load_button(btn[IN_XFER]),
    .btn_open(btn[IN_OPEN]), .din_on_load(btn[IN_ONLD]), .din_off_load(btn[IN_OFFLD]),
    .gen_available(gen_available), .in_sync(in_sync), .bus_live(bus_live),
    .ramp_done(ramp_done), .inter_set_comms_link(link), .alarm_cond(alm),
    .engine_run(engine_run), .sync_req(sync_req), .ramp_off_req(ramp_off_req),
    .gen_close(gen_close), .op_mode(op_mode), .irq(irq));
  gms_partner i_gms_partner (.aclk(aclk), .aresetn(aresetn), .engine_run(engine_run),
    .sync_req(sync_req), .ramp_off_req(ramp_off_req), .dly(dly),
    .gen_available(gen_available), .in_sync(in_sync), .ramp_done(ramp_done));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    if (n_mismatch == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Item release is decided on the ready seen at the edge, so no item is taken twice
  task wr(input logic [5:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid && k < 50);
    r = bresp;
    bready <= 0;
    chk({31'h0, k < 50}, 32'h1);
    if (k >= 50) print_verdict;
  endtask
  task rd(input logic [5:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 0;
    end while (!rvalid && k < 50);
    d = rdata;
    r = rresp;
    rready <= 0;
    chk({31'h0, k < 50}, 32'h1);
    if (k >= 50) print_verdict;
  endtask
  // Long enough for the four-edge input pipeline on both edges of the press
  task press(input int b);
    @(posedge aclk);
    btn[b] <= 1;
    repeat (8) @(posedge aclk);
    btn[b] <= 0;
    repeat (8) @(posedge aclk);
  endtask
  task wt(input int b, input logic v, input int lim);
    c = 0;
    while (outs[b] !== v && c < lim) begin
      @(posedge aclk);
      c++;
    end
    chk({31'h0, outs[b]}, {31'h0, v});
    if (outs[b] !== v) print_verdict;
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    #100us;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_RET_DELAY);
    chk(d, {16'h0, RET_DELAY_RST});
    rd(ADDR_COOL_TIME);
    chk(d, {16'h0, COOL_TIME_RST});
    rd(6'h18);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    wr(6'h1c, 32'h1);
    chk(r, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hffff_ffff);
    rd(ADDR_STATUS);
    chk(d, 32'h0);
    press(IN_START);
    chk(engine_run, 0);
    alm <= 8'h03;
    repeat (10) @(posedge aclk);
    alm <= 8'h02;
    repeat (10) @(posedge aclk);
    rd(ADDR_ALARMS);
    chk(d, 32'h3);
    press(IN_STOP);
    rd(ADDR_ALARMS);
    chk(d, 32'h2);
    press(IN_MAN);
    chk(op_mode, 2'h1);
    press(IN_START);
    chk({engine_run, gen_close}, 2'b10);
    bus_live <= 1;
    dly <= 8'd40;
    repeat (50) @(posedge aclk);
    press(IN_XFER);
    chk({sync_req, gen_close}, 2'b10);
    wt(3, 1, 60);
    press(IN_OPEN);
    chk({ramp_off_req, gen_close}, 2'b11);
    wt(3, 0, 60);
    dly <= 8'd1;
    press(IN_ONLD);
    wt(3, 1, 30);
    repeat (10) @(posedge aclk);
    chk(gen_close, 1);
    press(IN_OFFLD);
    wt(3, 0, 30);
    dly <= 8'd100;
    bus_live <= 0;
    press(IN_XFER);
    chk({sync_req, gen_close}, 2'b01);
    press(IN_STOP);
    chk({engine_run, gen_close, op_mode}, 4'h0);
    bus_live <= 1;
    dly <= 8'd3;
    wr(ADDR_RET_DELAY, 32'h1);
    wr(ADDR_COOL_TIME, 32'h2);
    wr(ADDR_INT_STAT, 32'h1f);
    wr(ADDR_INT_MASK, 32'h1 << EV_CLOSE);
    press(IN_AUTO);
    chk({irq, op_mode}, 3'h2);
    link <= 4'h4;
    wt(3, 1, 200);
    chk(engine_run, 1);
    repeat (3) @(posedge aclk);
    chk(irq, 1);
    wr(ADDR_INT_STAT, 32'h1 << EV_CLOSE);
    repeat (2) @(posedge aclk);
    chk(irq, 0);
    link <= 4'h0;
    wt(3, 0, 200);
    chk({31'h0, c >= 20}, 32'h1);
    chk(engine_run, 1);
    wt(0, 0, 100);
    chk({31'h0, c >= 20 && c <= 31}, 32'h1);
    repeat (5) @(posedge aclk);
    chk({engine_run, op_mode}, 3'h2);
    link <= 4'h1;
    wt(0, 1, 50);
    print_verdict;
  end
endmodule
